// >>> baud_gen_pkg.sv
// Constants and carrier types for the serial port bit-rate generator
`default_nettype none
package baud_gen_pkg;
    // Clock source codes
    localparam logic [1:0] SRC_PCLK = 2'h0;
    localparam logic [1:0] SRC_PCLK_DIV = 2'h1;
    localparam logic [1:0] SRC_EXT_PIN = 2'h3;
    // Prescaler factor for the divided source (product dependent)
    localparam int PRESCALE = 8;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
    // Operating mode codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_SPI_MASTER = 4'hE;
    localparam logic [3:0] MODE_SPI_SLAVE = 4'hF;
    // Divider widths and values
    localparam int DIV_W = 16;
    localparam int FRAC_W = 3;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
    localparam logic [FRAC_W-1:0] FRAC_ZERO = 3'h0;
    localparam logic [FRAC_W-1:0] FRAC_STEPS = 3'h7;
    // Oversampling counts: 16 when bit clear, 8 when set
    localparam logic [3:0] OVS16_LAST = 4'hF;
    localparam logic [3:0] OVS8_LAST = 4'h7;

    typedef struct packed {
        logic [1:0] clock_source_select;
        logic [3:0] operating_mode;
        logic oversample_by8;
    } port_mode_reg_s;

    typedef struct packed {
        logic [DIV_W-1:0] integer_divisor;
        logic [FRAC_W-1:0] fraction_field;
    } rate_divider_reg_s;

    typedef struct packed {
        logic [2:0] sync;
        logic ext_level;
        logic [3:0] pre_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic [FRAC_W+1:0] frac_acc;
        logic stretch;
        logic [3:0] ovs_cnt;
        logic sample_tick;
        logic bit_tick;
    } gen_state_s;
endpackage : baud_gen_pkg
`default_nettype wire

// >>> ext_clk_model.sv
// Remote serial device that drives the external clock pin
`default_nettype none
module ext_clk_model #(
    parameter int HALF = 3
) (
    input wire logic mclk_i,
    input wire logic run_i,
    output logic sck_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial sck_o = 1'h0;
    // ----------------------------------------
    // Pin clock, still and low outside frames
    // ----------------------------------------
    always @(posedge mclk_i)
    begin
        cnt = (run_i && cnt < HALF - 1) ? cnt + 1 : 0;
        if (!run_i)
            sck_o <= 1'h0;
        else if (cnt == 0)
            sck_o <= ~sck_o;
    end
endmodule : ext_clk_model
`default_nettype wire

// >>> serial_port_baud_generator.sv
// Bit-rate generator and pin roles of a serial port
//
// Notes on behaviour
// - Source: peripheral clock, prescaled, or pin
// - Sixteen-bit integer divider from divisor field
// - Divisor zero gives no rate clock
// - Divisor one passes source through undivided
// - Sample tick divided again to bit tick
// - Oversample 16 when clear, 8 when set
// - Rate equals source over 8(2-over)divisor
// - Nonzero fraction enables eighth-step division
// - Fraction used only in normal mode
// - Fractional rate adds fraction over eight
// - Transmit pin: data, MOSI or MISO
// - Receive pin: data, MISO or MOSI
// - Clear-to-send low, chip select in SPI master and slave
// - Request-to-send low, chip select in master
// - One rate clock serves receiver and transmitter
// - Clock gating resumes from held state
// - Source code three selects pin clock
`default_nettype none
module serial_port_baud_generator (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire baud_gen_pkg::port_mode_reg_s port_mode_reg_i,
    input wire baud_gen_pkg::rate_divider_reg_s rate_divider_reg_i,
    input wire logic ext_clk_i,
    input wire logic tx_data_i,
    output logic txd_o,
    input wire logic rxd_i,
    output logic rx_data_o,
    input wire logic cts_n_i,
    output logic clear_to_send_o,
    output logic spi_chip_select_o,
    input wire logic request_to_send_i,
    input wire logic spi_select_slave_i,
    output logic rts_n_o,
    output logic sample_tick_o,
    output logic bit_tick_o
);
    baud_gen_pkg::gen_state_s s_q;
    baud_gen_pkg::gen_state_s s_d;
    logic src_tick;
    logic ext_edge;
    logic frac_on;
    logic spi_mode;
    logic div_hit;
    logic [3:0] ovs_last;
    logic [baud_gen_pkg::FRAC_W+1:0] acc_sum;

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    assign ext_edge = (s_q.sync[1] == s_q.sync[2]) && (s_q.sync[2] != s_q.ext_level)
        && s_q.sync[2];
    assign spi_mode = (port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_SPI_MASTER)
        || (port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_SPI_SLAVE);
    assign frac_on = (rate_divider_reg_i.fraction_field != baud_gen_pkg::FRAC_ZERO)
        && (port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_NORMAL);
    assign ovs_last = port_mode_reg_i.oversample_by8 ? baud_gen_pkg::OVS8_LAST
        : baud_gen_pkg::OVS16_LAST;
    assign acc_sum = s_q.frac_acc + {2'b00, rate_divider_reg_i.fraction_field};

    always_comb
    begin
        case (port_mode_reg_i.clock_source_select)
            baud_gen_pkg::SRC_PCLK: src_tick = 1'b1;
            baud_gen_pkg::SRC_PCLK_DIV: src_tick = (s_q.pre_cnt == baud_gen_pkg::PRESCALE_LAST);
            baud_gen_pkg::SRC_EXT_PIN: src_tick = ext_edge;
            default: src_tick = 1'b0;
        endcase
    end

    // Divider reaches its last count; fraction stretches by one source tick
    assign div_hit = src_tick && !s_q.stretch
        && (s_q.div_cnt >= rate_divider_reg_i.integer_divisor - baud_gen_pkg::DIV_ONE);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.sync = {s_q.sync[1:0], ext_clk_i};
        if (s_q.sync[1] == s_q.sync[2])
        begin
            s_d.ext_level = s_q.sync[2];
        end
        if (s_q.pre_cnt == baud_gen_pkg::PRESCALE_LAST)
        begin
            s_d.pre_cnt = 4'h0;
        end
        else
        begin
            s_d.pre_cnt = s_q.pre_cnt + 4'h1;
        end
        s_d.sample_tick = 1'b0;
        s_d.bit_tick = 1'b0;
        if (rate_divider_reg_i.integer_divisor == baud_gen_pkg::DIV_ZERO)
        begin
            s_d.div_cnt = baud_gen_pkg::DIV_ZERO;
            s_d.stretch = 1'b0;
        end
        else if (src_tick)
        begin
            if (s_q.stretch)
            begin
                s_d.stretch = 1'b0;
                s_d.sample_tick = 1'b1;
            end
            else if (div_hit)
            begin
                s_d.div_cnt = baud_gen_pkg::DIV_ZERO;
                if (frac_on && acc_sum > {2'b00, baud_gen_pkg::FRAC_STEPS})
                begin
                    s_d.stretch = 1'b1;
                    s_d.frac_acc = acc_sum - 5'h08;
                end
                else
                begin
                    s_d.sample_tick = 1'b1;
                    s_d.frac_acc = frac_on ? acc_sum : 5'h00;
                end
            end
            else
            begin
                s_d.div_cnt = s_q.div_cnt + baud_gen_pkg::DIV_ONE;
            end
        end
        if (s_d.sample_tick)
        begin
            if (s_q.ovs_cnt >= ovs_last)
            begin
                s_d.ovs_cnt = 4'h0;
                s_d.bit_tick = 1'b1;
            end
            else
            begin
                s_d.ovs_cnt = s_q.ovs_cnt + 4'h1;
            end
        end
    end

    // State is held whenever the clock stops, so work resumes where it left
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sample_tick_o = s_q.sample_tick;
    assign bit_tick_o = s_q.bit_tick;

    // ----------------------------------------------------------------
    // Pin roles
    // ----------------------------------------------------------------
    assign txd_o = tx_data_i;
    assign rx_data_o = rxd_i;
    assign clear_to_send_o = !cts_n_i;
    assign spi_chip_select_o = spi_mode && !cts_n_i;
    assign rts_n_o = (port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_SPI_MASTER)
        ? !spi_select_slave_i : !request_to_send_i;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_zero_no_tick: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rate_divider_reg_i.integer_divisor == baud_gen_pkg::DIV_ZERO)[*2] |-> !sample_tick_o)
        else $error("sample tick with divisor zero");
    chk_bypass_rate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ($stable(rate_divider_reg_i) && $stable(port_mode_reg_i)
        && rate_divider_reg_i.integer_divisor == baud_gen_pkg::DIV_ONE
        && port_mode_reg_i.clock_source_select == baud_gen_pkg::SRC_PCLK
        && rate_divider_reg_i.fraction_field == baud_gen_pkg::FRAC_ZERO) |=> sample_tick_o)
        else $error("bypass did not pass source through");
    chk_bit_needs_sample: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        bit_tick_o |-> sample_tick_o)
        else $error("bit tick without sample tick");
    chk_ovs_count: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (s_q.ovs_cnt <= baud_gen_pkg::OVS16_LAST))
        else $error("oversample counter out of range");
    chk_div_bound: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $stable(rate_divider_reg_i.integer_divisor)
        && rate_divider_reg_i.integer_divisor != baud_gen_pkg::DIV_ZERO
        |-> s_q.div_cnt < rate_divider_reg_i.integer_divisor
        || $changed(rate_divider_reg_i.integer_divisor))
        else $error("divider count past divisor");
    chk_frac_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (port_mode_reg_i.operating_mode != baud_gen_pkg::MODE_NORMAL) |=> !s_q.stretch
        || $past(s_q.stretch))
        else $error("fraction used outside normal mode");
    chk_slave_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        spi_chip_select_o |-> !cts_n_i)
        else $error("chip select without low clear-to-send");
    chk_master_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_SPI_MASTER)
        |-> rts_n_o == !spi_select_slave_i)
        else $error("master chip select wrong");
    chk_ext_edge_sync: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ext_edge |-> $past(ext_clk_i, 3))
        else $error("pin edge not from synchronised level");

    chk_ext_edge_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ext_edge |-> !s_q.ext_level)
        else $error("pin edge taken without a rising level");

    // ----------------------------------------------------------------
    // Source checks
    // ----------------------------------------------------------------
    chk_prescale_phase: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sample_tick_o && $stable(port_mode_reg_i)
        && port_mode_reg_i.clock_source_select == baud_gen_pkg::SRC_PCLK_DIV)
        |-> (s_q.pre_cnt == 4'h0))
        else $error("prescaled tick off the prescaler wrap");

    chk_prescale_wrap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (s_q.pre_cnt <= baud_gen_pkg::PRESCALE_LAST))
        else $error("prescaler count out of range");

    chk_ext_tick_src: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sample_tick_o && $stable(port_mode_reg_i)
        && port_mode_reg_i.clock_source_select == baud_gen_pkg::SRC_EXT_PIN)
        |-> $past(ext_edge))
        else $error("pin source tick without a pin edge");

    chk_idle_source: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ($stable(port_mode_reg_i)
        && port_mode_reg_i.clock_source_select != baud_gen_pkg::SRC_PCLK
        && port_mode_reg_i.clock_source_select != baud_gen_pkg::SRC_PCLK_DIV
        && port_mode_reg_i.clock_source_select != baud_gen_pkg::SRC_EXT_PIN)
        |-> !sample_tick_o)
        else $error("tick from an unused source code");

    chk_ext_level_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (s_q.sync[1] != s_q.sync[2]) |=> (s_q.ext_level == $past(s_q.ext_level)))
        else $error("pin level taken before it settled");

    // ----------------------------------------------------------------
    // Divider checks
    // ----------------------------------------------------------------
    chk_div_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (src_tick && !s_q.stretch && !div_hit
        && rate_divider_reg_i.integer_divisor != baud_gen_pkg::DIV_ZERO)
        |=> (s_q.div_cnt == $past(s_q.div_cnt) + baud_gen_pkg::DIV_ONE))
        else $error("divider did not count a source tick");

    chk_div_restart: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        div_hit |=> (s_q.div_cnt == baud_gen_pkg::DIV_ZERO))
        else $error("divider not restarted at its last count");

    chk_sample_spacing: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sample_tick_o && $stable(rate_divider_reg_i)
        && rate_divider_reg_i.integer_divisor > baud_gen_pkg::DIV_ONE)
        |=> !sample_tick_o)
        else $error("back to back sample ticks with divisor above one");

    chk_bit_spacing: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (bit_tick_o && $stable(rate_divider_reg_i)
        && rate_divider_reg_i.integer_divisor > baud_gen_pkg::DIV_ONE)
        |=> !bit_tick_o)
        else $error("back to back bit ticks");

    chk_zero_no_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rate_divider_reg_i.integer_divisor == baud_gen_pkg::DIV_ZERO)[*2] |-> !bit_tick_o)
        else $error("bit tick with divisor zero");

    chk_zero_clears: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rate_divider_reg_i.integer_divisor == baud_gen_pkg::DIV_ZERO)
        |=> (s_q.div_cnt == baud_gen_pkg::DIV_ZERO && !s_q.stretch))
        else $error("divider kept counting with divisor zero");

    chk_stretch_frac: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(s_q.stretch) |-> $past(frac_on))
        else $error("period stretched without fraction");

    chk_no_frac_spi: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (port_mode_reg_i.operating_mode != baud_gen_pkg::MODE_NORMAL && div_hit)
        |=> (s_q.frac_acc == 5'h00))
        else $error("fraction accumulated outside normal mode");

    chk_stretch_tick: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (s_q.stretch && src_tick
        && rate_divider_reg_i.integer_divisor != baud_gen_pkg::DIV_ZERO) |=> sample_tick_o)
        else $error("stretched period gave no tick");

    chk_frac_acc_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (s_q.frac_acc <= {2'b00, baud_gen_pkg::FRAC_STEPS}))
        else $error("fraction accumulator out of range");

    chk_bit_ovs_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        bit_tick_o |-> (s_q.ovs_cnt == 4'h0))
        else $error("bit tick without oversample wrap");

    chk_ovs_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (sample_tick_o && !bit_tick_o) |-> (s_q.ovs_cnt != 4'h0))
        else $error("sample tick not counted");

    // ----------------------------------------------------------------
    // Pin checks
    // ----------------------------------------------------------------
    chk_txd_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        txd_o == tx_data_i)
        else $error("transmit pin not following data");

    chk_rxd_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rx_data_o == rxd_i)
        else $error("receive data not following pin");

    chk_cts_level: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        clear_to_send_o == !cts_n_i)
        else $error("clear-to-send not active low");

    chk_slave_idle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !spi_mode |-> !spi_chip_select_o)
        else $error("chip select outside spi modes");

    chk_rts_normal: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (port_mode_reg_i.operating_mode != baud_gen_pkg::MODE_SPI_MASTER)
        |-> rts_n_o == !request_to_send_i)
        else $error("request-to-send wrong outside master mode");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    cov_prescale_tick: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        sample_tick_o && port_mode_reg_i.clock_source_select == baud_gen_pkg::SRC_PCLK_DIV);
    cov_spi_master: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        port_mode_reg_i.operating_mode == baud_gen_pkg::MODE_SPI_MASTER && !rts_n_o);
    cov_bit_tick: cover property (@(posedge mclk_i) disable iff (!rstn_i) bit_tick_o);
    cov_stretch: cover property (@(posedge mclk_i) disable iff (!rstn_i) s_q.stretch);
    cov_ext_tick: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        ext_edge && port_mode_reg_i.clock_source_select == baud_gen_pkg::SRC_EXT_PIN);
endmodule : serial_port_baud_generator
`default_nettype wire

// >>> serial_port_baud_generator_tb_top.sv
// Self-checking bench of the bit-rate generator
`default_nettype none
module serial_port_baud_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, rstn_i, ext_clk_i, run, tx_data_i, rxd_i, cts_n_i, req_i, sel_i;
    logic txd_o, rx_data_o, cts_o, cs_o, rts_n_o, sample_tick_o, bit_tick_o;
    baud_gen_pkg::port_mode_reg_s pm;
    baud_gen_pkg::rate_divider_reg_s rd;
    int error_cnt = 0;
    int checks = 0;
    int c;
    logic [3:0] modes [3] = '{4'h0, 4'hE, 4'hF};
    serial_port_baud_generator u_serial_port_baud_generator (.mclk_i(mclk_i),
        .rstn_i(rstn_i), .port_mode_reg_i(pm), .rate_divider_reg_i(rd),
        .ext_clk_i(ext_clk_i), .tx_data_i(tx_data_i), .txd_o(txd_o), .rxd_i(rxd_i),
        .rx_data_o(rx_data_o), .cts_n_i(cts_n_i), .clear_to_send_o(cts_o),
        .spi_chip_select_o(cs_o), .request_to_send_i(req_i),
        .spi_select_slave_i(sel_i), .rts_n_o(rts_n_o),
        .sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o));
    ext_clk_model u_ext_clk_model (.mclk_i(mclk_i), .run_i(run), .sck_o(ext_clk_i));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cfg(input logic [1:0] src, input logic [3:0] md, input logic o8,
        input logic [15:0] dv, input logic [2:0] fr);
        @(posedge mclk_i);
        #2;
        pm = '{src, md, o8};
        rd = '{dv, fr};
    endtask : cfg
    // Cycles spanned by n periods of the chosen tick, after two settling ticks
    task automatic span(input logic use_bit, input int n, output int cyc);
        int seen;
        int k;
        seen = 0;
        cyc = 0;
        for (k = 0; k < 60000 && seen < n + 2; k++)
        begin
            @(posedge mclk_i);
            #1;
            if (seen >= 2)
                cyc++;
            if ((use_bit ? bit_tick_o : sample_tick_o) === 1'h1)
                seen++;
        end
        if (seen < n + 2)
        begin
            error_cnt++;
            close_out();
        end
    endtask : span
    // ----------------------------------------
    // Clock and main sequence
    // ----------------------------------------
    initial
    begin
        mclk_i = 1'h0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial
    begin
        {rstn_i, run, tx_data_i, rxd_i, cts_n_i, req_i, sel_i} = 7'h00;
        pm = '{baud_gen_pkg::SRC_PCLK, baud_gen_pkg::MODE_NORMAL, 1'h0};
        rd = '{16'h0003, baud_gen_pkg::FRAC_ZERO};
        repeat (5) @(posedge mclk_i);
        #2 rstn_i = 1'h1;
        span(0, 4, c); check(c, 12);
        span(1, 1, c); check(c, 48);
        cfg(2'h0, 4'h0, 1'h1, 16'h0003, 3'h0); span(1, 1, c); check(c, 24);
        cfg(2'h0, 4'h0, 1'h0, 16'h0001, 3'h0); span(0, 8, c); check(c, 8);
        cfg(2'h1, 4'h0, 1'h0, 16'h0002, 3'h0); span(0, 4, c); check(c, 64);
        cfg(2'h1, 4'h0, 1'h1, 16'h0002, 3'h0); span(1, 1, c); check(c, 128);
        cfg(2'h3, 4'h0, 1'h0, 16'h0002, 3'h0);
        run = 1'h1;
        span(0, 4, c); check(c, 48);
        cfg(2'h0, 4'h0, 1'h0, 16'h4001, 3'h0);
        run = 1'h0;
        span(0, 1, c); check(c, 16385);
        cfg(2'h0, 4'h0, 1'h0, 16'h0003, 3'h7); span(0, 8, c); check(c, 31);
        cfg(2'h0, 4'h0, 1'h0, 16'h0002, 3'h4); span(0, 16, c); check(c, 40);
        cfg(2'h0, 4'hE, 1'h0, 16'h0003, 3'h7); span(0, 8, c); check(c, 24);
        for (int z = 0; z < 2; z++)
        begin
            cfg(z ? 2'h2 : 2'h0, 4'h0, 1'h0, z ? 16'h0003 : 16'h0000, 3'h0);
            c = 0;
            repeat (100)
            begin
                @(posedge mclk_i);
                #1;
                if (sample_tick_o !== 1'h0 || bit_tick_o !== 1'h0)
                    c++;
            end
            check(c, 0);
        end
        for (int m = 0; m < 3; m++)
            for (int v = 0; v < 4; v++)
            begin
                cfg(2'h0, modes[m], 1'h0, 16'h0003, 3'h0);
                {cts_n_i, sel_i} = {2{v[1]}};
                {tx_data_i, rxd_i, req_i} = {v[0], ~v[0], v[0]};
                #1;
                check({txd_o, rx_data_o, cts_o, cs_o, rts_n_o}, {v[0], ~v[0], ~v[1],
                    (m > 0) & ~v[1], (m == 1) ? ~v[1] : ~v[0]});
            end
        close_out();
    end
endmodule : serial_port_baud_generator_tb_top
`default_nettype wire
